// file: bench/adc_core_model.sv
// Behavioural converter core that answers the sequencer
`timescale 1ns/1ps
module adc_core_model (
   // Sequencer side
   input wire logic ref_clk,
   input wire logic convStart,
   input wire logic convAbort,
   input wire logic [3:0] convChannel,
   input wire logic convDiff,
   input wire logic convHalve,
   output logic convDone,
   output logic [11:0] convResult,
   // Bench control
   input wire logic slow,
   input wire logic [5:0] salt
);
   int cnt = 0;
   logic [11:0] code = '0;
   initial convDone = 1'b0;
   initial convResult = 12'h5A5;
   // Code carries channel, range and pairing so the bench sees where each lands
   always @(posedge ref_clk) begin
      convDone <= 1'b0;
      convResult <= ~convResult;
      if (convStart) begin
         cnt <= slow ? 250 : 20;
         code <= {convChannel, convHalve, convDiff, salt};
      end else if (convAbort) begin
         cnt <= 0;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
         if (cnt == 1) begin
            convDone <= 1'b1;
            // Pairs come out offset binary
            convResult <= convDiff ? code ^ 12'h800 : code;
         end
      end
   end
endmodule

// file: bench/primary_adc_sequencer_asserts.sv
// Port-level checks of the converter sequencer
`timescale 1ns/1ps
module primary_adc_sequencer_asserts (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Converter side
   input wire logic conv_done_n,
   input wire logic convStart,
   input wire logic convAbort,
   input wire logic [3:0] convChannel,
   input wire logic convDiff,
   input wire logic convDone,
   // Bus side
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   a_chan_stable: assert property (!convStart |-> $stable(convChannel))
      else $error("channel moved between starts");
   a_diff_even: assert property (convStart && convDiff |-> !convChannel[0] && convChannel < 4'h4)
      else $error("pair conversion on bad channel");
   a_upper_single: assert property (convStart && convChannel > 4'h3 |-> !convDiff)
      else $error("upper channel paired");
   a_abort_restart: assert property (convAbort |=> convStart)
      else $error("no restart after abort");
   a_done_cause: assert property ($fell(conv_done_n) |-> $past(convDone, 3) || $past(s_axi_bvalid))
      else $error("done pin without result");
   a_done_low: assert property ($fell(conv_done_n) |-> !conv_done_n [*8])
      else $error("done pin low too short");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready |-> ##[1:3] s_axi_bvalid)
      else $error("write not answered");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read not answered");
endmodule
bind primary_adc_sequencer primary_adc_sequencer_asserts u_chk (.*);

// file: bench/primary_adc_sequencer_tb.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module primary_adc_sequencer_tb;
   import adc_seq_pkg::*;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic ext_trigger_n = 1'b1;
   logic conv_done_n, convStart, convAbort, convDiff, convHalve, convDone, slow = 1'b0;
   logic [3:0] convChannel;
   logic [11:0] convResult;
   logic [5:0] salt = '0;
   logic [7:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, v;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r, pair;
   logic [15:0] chsel, gain, known = '0;
   logic [11:0] expData [16];
   logic d;
   int bad_count = 0, compares = 0, seed = 35992, aborts = 0, n;
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (convAbort === 1'b1) aborts++;
   primary_adc_sequencer dut (.ref_clk(ref_clk), .arst_n(arst_n), .ext_trigger_n(ext_trigger_n),
      .conv_done_n(conv_done_n), .convStart(convStart), .convAbort(convAbort), .convChannel(convChannel),
      .convDiff(convDiff), .convHalve(convHalve), .convDone(convDone), .convResult(convResult),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'b000), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'b000), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   adc_core_model core (.ref_clk(ref_clk), .convStart(convStart), .convAbort(convAbort),
      .convChannel(convChannel), .convDiff(convDiff), .convHalve(convHalve), .convDone(convDone),
      .convResult(convResult), .slow(slow), .salt(salt));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict();
      if (bad_count == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] resp);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= dat;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (aw || w) begin
         @(posedge ref_clk);
         if (aw && awready) begin
            awvalid <= 1'b0;
            aw = 1'b0;
         end
         if (w && wready) begin
            wvalid <= 1'b0;
            w = 1'b0;
         end
      end
      // Late bready makes the slave hold its answer for a cycle
      do @(posedge ref_clk); while (bvalid !== 1'b1);
      bready <= 1'b1;
      @(posedge ref_clk);
      resp = bresp;
      bready <= 1'b0;
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge ref_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge ref_clk); while (rvalid !== 1'b1);
      dat = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
   task automatic trig(input logic ext, input logic [31:0] cfg);
      if (ext) begin
         @(posedge ref_clk);
         ext_trigger_n <= 1'b0;
         repeat (4) @(posedge ref_clk);
         ext_trigger_n <= 1'b1;
      end else axw(CFG0_OFFS, cfg, r);
   endtask
   task automatic waitDone();
      do @(posedge ref_clk); while (conv_done_n !== 1'b0);
   endtask
   initial begin
      #1_000_000;
      bad_count++;
      give_verdict();
   end
   initial begin
      repeat (8) @(posedge ref_clk);
      arst_n <= 1'b1;
      axr(CHSEL_OFFS, v, r);
      chk(v, {16'h0000, CHSEL_RESET}, "chsel reset");
      axr(8'h20, v, r);
      chk({v[3:0], r}, {4'h0, RESP_SLVERR}, "unmapped read");
      axw(DATA_BASE_OFFS, 32'h0000_0FFF, r);
      chk(r, RESP_SLVERR, "data write");
      for (int p = 0; p < 6; p++) begin
         chsel = (p == 0) ? 16'hFFFF : 16'($random(seed));
         gain = 16'($random(seed));
         pair = (p < 2) ? 2'b11 : 2'($random(seed));
         if (pair[0]) {chsel[1], gain[1]} = {chsel[0], gain[0]};
         if (pair[1]) {chsel[3], gain[3]} = {chsel[2], gain[2]};
         if (chsel == 16'h0000) chsel = 16'h8000;
         salt <= 6'($random(seed));
         slow <= p[1];
         axw(CHSEL_OFFS, {16'h0000, chsel}, r);
         axw(PAIR_OFFS, {30'h0, pair}, r);
         axw(GAIN_OFFS, {16'h0000, gain}, r);
         chk(r, RESP_OKAY, "bresp");
         trig(p[0], 32'h0000_0001);
         waitDone();
         axr(CFG0_OFFS, v, r);
         chk(v[CFG0_DATA_AVAIL_FLAG_BIT], 1'b1, "flag");
         chk(conv_done_n, 1'b0, "done pin");
         for (int c = 0; c < 16; c++) begin
            d = (c < 4) && pair[c / 2];
            if (chsel[c] && !(d && c[0])) begin
               expData[c] = {4'(c), gain[c], d, salt};
               known[c] = 1'b1;
            end
            axr(DATA_BASE_OFFS + 8'(4 * c), v, r);
            if (known[c]) chk(v, {20'h0, expData[c]}, "data");
         end
      end
      axw(CHSEL_OFFS, 32'h0000_000F, r);
      axw(PAIR_OFFS, 32'h0000_0000, r);
      trig(1'b0, 32'h0000_0001);
      repeat (3) @(posedge ref_clk);
      chk(conv_done_n, 1'b1, "done release");
      do @(posedge ref_clk); while (!(convStart === 1'b1 && convChannel === 4'h1));
      trig(1'b1, 32'h0);
      do @(posedge ref_clk); while (convStart !== 1'b1);
      chk(convChannel, 4'h0, "restart channel");
      chk(aborts, 1, "aborts");
      waitDone();
      slow <= 1'b0;
      axw(CHSEL_OFFS, 32'h0000_0001, r);
      trig(1'b0, 32'h0000_0003);
      for (int k = 0; k < 2; k++) begin
         waitDone();
         n = 0;
         while (conv_done_n === 1'b0) begin
            n++;
            @(posedge ref_clk);
         end
         chk(n, DONE_PULSE_CYCLES, "pulse width");
      end
      axw(CHSEL_OFFS, 32'h0000_0000, r);
      // Let the running pass drain so the empty trigger meets an idle sequencer
      repeat (400) @(posedge ref_clk);
      axw(CFG0_OFFS, 32'h0000_0001, r);
      repeat (3) @(posedge ref_clk);
      chk(conv_done_n, 1'b1, "empty trigger");
      axr(CFG0_OFFS, v, r);
      chk(v[CFG0_BUSY_BIT], 1'b0, "empty busy");
      chk(aborts, 1, "idle aborts");
      give_verdict();
   end
endmodule

// file: rtl/adc_seq_pkg.sv
// Constants, register map and types for the primary converter sequencer
// ----------------------------------------------------------------------
// Contract
// - Sixteen converter inputs; channels 4 to 15 are always single-ended.
// - Inputs 0 to 3 are four single-ended inputs or two differential pairs.
// - Sustain 500 thousand samples per second across the multiplexed inputs; the code spaces samples 201 cycles apart, about 497.5 thousand per second.
// - Per-input range is one or two times reference; doubled range halves input.
// - A falling edge on the active-low trigger pin starts a sequence.
// - Writing the internal convert bit also starts a sequence.
// - Channels converted in a sequence come from the channel selection register.
// - Any new trigger abandons the running conversion at once and restarts.
// - After a restart, begin again at the first enabled channel.
// - Each finished channel result goes straight into its staging register.
// - After the last channel, all staging registers copy to data registers together.
// - Data register update waits while a data register transfer is in progress.
// - Channel n result lands in data register n; all sixteen readable.
// - Single-ended results are stored as unsigned straight binary.
// - Differential results are stored as two's complement.
// - The active-low done pin follows the data-available flag; the code does so in direct mode only, pulsing it in auto mode.
// - Direct mode: after the group converts, set the flag and drive done low.
// - Auto mode: each completed pass gives a 1 us low pulse on done.
// - Enabled channels convert in ascending channel-number order.
// - Gain bit 0 selects one times reference, 1 selects twice reference.
// ----------------------------------------------------------------------
package adc_seq_pkg;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int SAMPLE_RATE_SPS = 500000;
   localparam int CLK_RATE_HZ = 1000000000 / CLK_PERIOD_NS;
   // Longest slot allowed for one sample, rounded down
   localparam int SAMPLE_CYCLES = CLK_RATE_HZ / SAMPLE_RATE_SPS;
   localparam int DONE_PULSE_NS = 1000;
   localparam int DONE_PULSE_CYCLES = DONE_PULSE_NS / CLK_PERIOD_NS;

   // ----------------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------------
   localparam int NUM_CHANNELS = 16;
   localparam int ADDR_W = 8;

   // ----------------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------------
   localparam logic [ADDR_W-1:0] CFG0_OFFS = 8'h00;
   localparam logic [ADDR_W-1:0] CHSEL_OFFS = 8'h04;
   localparam logic [ADDR_W-1:0] PAIR_OFFS = 8'h08;
   localparam logic [ADDR_W-1:0] GAIN_OFFS = 8'h0C;
   localparam logic [ADDR_W-1:0] DATA_BASE_OFFS = 8'h40;

   // CFG0 field positions
   localparam int CFG0_INTERNAL_CONVERT_BIT_BIT = 0;
   localparam int CFG0_AUTO_BIT = 1;
   localparam int CFG0_DATA_AVAIL_FLAG_BIT = 2;
   localparam int CFG0_BUSY_BIT = 3;

   // Reset values
   localparam logic [15:0] CHSEL_RESET = 16'h0000;
   localparam logic [1:0] PAIR_RESET = 2'h0;
   localparam logic [15:0] GAIN_RESET = 16'h0000;
   localparam logic AUTO_RESET = 1'b0;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_START = 2'b01,
      SEQ_CONV = 2'b10,
      SEQ_PACE = 2'b11
   } seq_state_t;

endpackage

// file: rtl/primary_adc_sequencer.sv
// Primary converter sequencer with AXI4-Lite register slave
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module primary_adc_sequencer #(
   parameter int RES_W = 12
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // External trigger pin
   input wire logic ext_trigger_n,
   // Conversion-done pin
   output logic conv_done_n,
   // Converter core
   output logic convStart,
   output logic convAbort,
   output logic [3:0] convChannel,
   output logic convDiff,
   output logic convHalve,
   input wire logic convDone,
   input wire logic [RES_W-1:0] convResult,
   // AXI4-Lite write address
   input wire logic [adc_seq_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [adc_seq_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import adc_seq_pkg::*;

   if (RES_W < 2 || RES_W > 32) begin : g_check
      $error("RES_W must lie between 2 and 32");
   end

   // ----------------------------------------------------------------------
   // Reset release and pin synchroniser
   // ----------------------------------------------------------------------
   logic rstMeta_reg;
   logic rstSync_reg;
   logic rst_n;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rstMeta_reg <= 1'b0;
         rstSync_reg <= 1'b0;
      end else begin
         rstMeta_reg <= 1'b1;
         rstSync_reg <= rstMeta_reg;
      end
   end
   assign rst_n = rstSync_reg;

   logic trigMeta_reg;
   logic trigSync_reg;
   logic trigLast_reg;

   // Idle level of the pin is high, so reset to high to avoid a false edge
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         trigMeta_reg <= 1'b1;
         trigSync_reg <= 1'b1;
         trigLast_reg <= 1'b1;
      end else begin
         trigMeta_reg <= ext_trigger_n;
         trigSync_reg <= trigMeta_reg;
         trigLast_reg <= trigSync_reg;
      end
   end

   // ----------------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------------
   logic autoMode_reg;
   logic [15:0] chSel_reg;
   logic [1:0] pairDiff_reg;
   logic [15:0] gain_reg;
   logic dataAvail_reg;
   logic swTrig_reg;
   logic [RES_W-1:0] stage_reg [NUM_CHANNELS];
   logic [RES_W-1:0] data_reg [NUM_CHANNELS];

   logic extFall;
   logic trigger;
   assign extFall = trigLast_reg & ~trigSync_reg;
   assign trigger = extFall | swTrig_reg;

   // ----------------------------------------------------------------------
   // AXI4-Lite write path
   // ----------------------------------------------------------------------
   logic awHeld_reg;
   logic wHeld_reg;
   logic [ADDR_W-1:0] awAddr_reg;
   logic [31:0] wData_reg;
   logic [3:0] wStrb_reg;
   logic doWrite;

   assign doWrite = awHeld_reg & wHeld_reg & ~s_axi_bvalid;

   // Address and data are taken independently, in either order
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         awHeld_reg <= 1'b0;
         wHeld_reg <= 1'b0;
         awAddr_reg <= '0;
         wData_reg <= '0;
         wStrb_reg <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         s_axi_awready <= ~awHeld_reg & ~(s_axi_awvalid & s_axi_awready);
         s_axi_wready <= ~wHeld_reg & ~(s_axi_wvalid & s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (awAddr_reg == CFG0_OFFS || awAddr_reg == CHSEL_OFFS || awAddr_reg == PAIR_OFFS ||
                awAddr_reg == GAIN_OFFS) begin
               s_axi_bresp <= RESP_OKAY;
            end else begin
               s_axi_bresp <= RESP_SLVERR;
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Control fields, byte lanes honoured
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         autoMode_reg <= AUTO_RESET;
         chSel_reg <= CHSEL_RESET;
         pairDiff_reg <= PAIR_RESET;
         gain_reg <= GAIN_RESET;
         swTrig_reg <= 1'b0;
      end else begin
         swTrig_reg <= 1'b0;
         if (doWrite) begin
            case (awAddr_reg)
               CFG0_OFFS: begin
                  if (wStrb_reg[0]) begin
                     swTrig_reg <= wData_reg[CFG0_INTERNAL_CONVERT_BIT_BIT];
                     autoMode_reg <= wData_reg[CFG0_AUTO_BIT];
                  end
               end
               CHSEL_OFFS: begin
                  if (wStrb_reg[0]) begin
                     chSel_reg[7:0] <= wData_reg[7:0];
                  end
                  if (wStrb_reg[1]) begin
                     chSel_reg[15:8] <= wData_reg[15:8];
                  end
               end
               PAIR_OFFS: begin
                  if (wStrb_reg[0]) begin
                     pairDiff_reg <= wData_reg[1:0];
                  end
               end
               GAIN_OFFS: begin
                  if (wStrb_reg[0]) begin
                     gain_reg[7:0] <= wData_reg[7:0];
                  end
                  if (wStrb_reg[1]) begin
                     gain_reg[15:8] <= wData_reg[15:8];
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // AXI4-Lite read path
   // ----------------------------------------------------------------------
   logic seqBusy;
   logic [31:0] rdValue;
   logic rdMapped;

   always_comb begin
      rdValue = 32'h0000_0000;
      rdMapped = 1'b1;
      // Only the data window decodes; upper addresses must not alias onto it
      if (s_axi_araddr[7:6] == DATA_BASE_OFFS[7:6] && s_axi_araddr[1:0] == 2'h0) begin
         rdValue[RES_W-1:0] = data_reg[4'(s_axi_araddr[5:2])];
      end else begin
         case (s_axi_araddr)
            CFG0_OFFS: begin
               rdValue[CFG0_AUTO_BIT] = autoMode_reg;
               rdValue[CFG0_DATA_AVAIL_FLAG_BIT] = dataAvail_reg;
               rdValue[CFG0_BUSY_BIT] = seqBusy;
            end
            CHSEL_OFFS: rdValue[15:0] = chSel_reg;
            PAIR_OFFS: rdValue[1:0] = pairDiff_reg;
            GAIN_OFFS: rdValue[15:0] = gain_reg;
            default: rdMapped = 1'b0;
         endcase
      end
   end

   // The read data stands in rdata while rvalid is high: that is the transfer window
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdValue;
            s_axi_rresp <= rdMapped ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Channel search
   // ----------------------------------------------------------------------
   // Lowest enabled channel at or above start; bit 4 set means none left
   function automatic logic [4:0] find_from(input logic [15:0] mask, input logic [4:0] start);
      logic [4:0] res;
      res = 5'h10;
      for (int i = NUM_CHANNELS - 1; i >= 0; i--) begin
         if (mask[i] && 5'(i) >= start) begin
            res = 5'(i);
         end
      end
      return res;
   endfunction

   logic [15:0] convMask;
   // Odd member of a differential pair is converted with its partner
   assign convMask = chSel_reg & ~{12'h000, pairDiff_reg[1], 1'b0, pairDiff_reg[0], 1'b0};

   logic [4:0] firstChan;
   assign firstChan = find_from(convMask, 5'h00);

   // ----------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------
   seq_state_t state_reg;
   logic [3:0] chan_reg;
   logic [3:0] nextChan_reg;
   logic [7:0] paceCnt_reg;
   logic commitPend_reg;
   logic passDone_reg;
   logic lastDiff;
   logic [RES_W-1:0] formatted;
   logic [4:0] following;

   assign seqBusy = (state_reg != SEQ_IDLE);
   assign lastDiff = (chan_reg < 4'h4) && pairDiff_reg[chan_reg[1]];
   // Core gives offset binary; a flipped sign bit turns it into two's complement
   assign formatted = lastDiff ? {~convResult[RES_W-1], convResult[RES_W-2:0]} : convResult;
   assign following = find_from(convMask, {1'b0, chan_reg} + 5'h01);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= SEQ_IDLE;
         chan_reg <= 4'h0;
         nextChan_reg <= 4'h0;
         paceCnt_reg <= 8'h00;
         convStart <= 1'b0;
         convAbort <= 1'b0;
         convChannel <= 4'h0;
         convDiff <= 1'b0;
         convHalve <= 1'b0;
         passDone_reg <= 1'b0;
      end else begin
         convStart <= 1'b0;
         convAbort <= 1'b0;
         passDone_reg <= 1'b0;
         if (paceCnt_reg != 8'hFF) begin
            paceCnt_reg <= paceCnt_reg + 8'h01;
         end
         if (trigger) begin
            convAbort <= seqBusy;
            if (firstChan[4]) begin
               state_reg <= SEQ_IDLE;
            end else begin
               nextChan_reg <= firstChan[3:0];
               state_reg <= SEQ_START;
            end
         end else begin
            case (state_reg)
               SEQ_IDLE: begin
               end
               SEQ_START: begin
                  chan_reg <= nextChan_reg;
                  convStart <= 1'b1;
                  convChannel <= nextChan_reg;
                  convDiff <= (nextChan_reg < 4'h4) && pairDiff_reg[nextChan_reg[1]];
                  convHalve <= gain_reg[nextChan_reg];
                  paceCnt_reg <= 8'h01;
                  state_reg <= SEQ_CONV;
               end
               SEQ_CONV: begin
                  if (convDone) begin
                     if (!following[4]) begin
                        nextChan_reg <= following[3:0];
                        state_reg <= SEQ_PACE;
                     end else begin
                        passDone_reg <= 1'b1;
                        if (autoMode_reg && !firstChan[4]) begin
                           nextChan_reg <= firstChan[3:0];
                           state_reg <= SEQ_PACE;
                        end else begin
                           state_reg <= SEQ_IDLE;
                        end
                     end
                  end
               end
               SEQ_PACE: begin
                  // Slot length fixes the aggregate rate while the core answers within the slot; a slower core stretches it
                  if (paceCnt_reg >= 8'(SAMPLE_CYCLES)) begin
                     state_reg <= SEQ_START;
                  end
               end
               default: state_reg <= SEQ_IDLE;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // Double buffering
   // ----------------------------------------------------------------------
   logic stageWrite;
   logic commitNow;
   assign stageWrite = (state_reg == SEQ_CONV) && convDone && !trigger;
   // Hold the copy while any read answer stands on the read channel
   assign commitNow = commitPend_reg && !s_axi_rvalid;

   always_ff @(posedge ref_clk) begin
      if (stageWrite) begin
         stage_reg[chan_reg] <= formatted;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         commitPend_reg <= 1'b0;
      end else if (passDone_reg) begin
         commitPend_reg <= 1'b1;
      end else if (commitNow) begin
         commitPend_reg <= 1'b0;
      end
   end

   for (genvar n = 0; n < NUM_CHANNELS; n++) begin : g_data
      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            data_reg[n] <= '0;
         end else if (commitNow) begin
            data_reg[n] <= stage_reg[n];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Data-available flag and done pin
   // ----------------------------------------------------------------------
   logic [7:0] pulseCnt_reg;

   // A completed pass wins over a trigger in the same cycle: the flag is set
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dataAvail_reg <= 1'b0;
      end else if (passDone_reg) begin
         dataAvail_reg <= 1'b1;
      end else if (trigger) begin
         dataAvail_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pulseCnt_reg <= 8'h00;
      end else if (passDone_reg && autoMode_reg) begin
         pulseCnt_reg <= 8'(DONE_PULSE_CYCLES);
      end else if (pulseCnt_reg != 8'h00) begin
         pulseCnt_reg <= pulseCnt_reg - 8'h01;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         conv_done_n <= 1'b1;
      end else if (autoMode_reg) begin
         conv_done_n <= (pulseCnt_reg == 8'h00);
      end else begin
         // Release on the trigger itself so a stale flag never shows as a short low pulse
         conv_done_n <= ~dataAvail_reg | trigger;
      end
   end

endmodule
